// ===== logic/aocr_pkg.sv
// constants for the converter offset and control register block
// assumes a single bus clock and a 16-bit raw code from the filter
package aocr_pkg;
    // ****************************************
    // register offsets
    // ****************************************
    localparam logic [11:0] OFF_CTRL  = 12'h000;
    localparam logic [11:0] OFF_ADC_CONFIGURATION  = 12'h004;
    localparam logic [11:0] OFF_MSTAT = 12'h008;
    localparam logic [11:0] OFF_MASK  = 12'h00C;
    localparam logic [11:0] OFF_RAW   = 12'h010;
    localparam logic [11:0] OFF_RES   = 12'h014;
    localparam logic [11:0] OFF_OFFS  = 12'h018;
    localparam logic [11:0] OFF_STAT  = 12'h020;
    localparam logic [11:0] OFF_HI    = 12'h024;
    localparam logic [11:0] OFF_LO    = 12'h028;
    // ****************************************
    // reset values and write masks
    // ****************************************
    localparam logic [31:0] CTRL_RST   = 32'h00000000;
    localparam logic [31:0] ADC_CONFIGURATION_RST   = 32'h0000000C;
    localparam logic [3:0]  MASK_RST   = 4'hF;
    localparam logic [31:0] HI_RST     = 32'h0FFFFFFF;
    localparam logic [31:0] CTRL_WMASK = 32'h000003A5;
    localparam logic [31:0] ADC_CONFIGURATION_WMASK = 32'h0007FFFE;
    // ****************************************
    // field positions
    // ****************************************
    localparam int CB_ON    = 0;
    localparam int CB_CALIBRATION_ENABLE = 1;
    localparam int CB_START = 2;
    localparam int CB_SRST  = 3;
    localparam int CB_STOP  = 4;
    localparam int CB_WCMP  = 5;
    localparam int CB_CALDS = 6;
    localparam int CB_AUTO  = 7;
    localparam int CB_MIC   = 8;
    localparam int CB_DMA   = 9;
    localparam int FB_OSR   = 6;
    localparam int FB_CONTINUOUS_SELECT  = 11;
    localparam int FB_BYP   = 18;
    localparam int FL_EOC   = 0;
    localparam int FL_CAL   = 1;
    localparam int FL_WIN   = 2;
    localparam int NFLAG    = 3;
    // ****************************************
    // full-scale factors
    // ****************************************
    localparam logic [15:0] FS_LO_FILT = 16'h4144;
    localparam logic [15:0] FS_HI_FILT = 16'h4BFA;
    localparam logic [15:0] FS_LO_BYP  = 16'h8000;
    localparam logic [15:0] FS_HI_BYP  = 16'h9503;
    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_NS   = 100;
    localparam int WAKE_NS  = 6000;
    localparam int WAKE_CYC = (WAKE_NS + CLK_NS - 1) / CLK_NS;
    // ****************************************
    // sequencer states
    // ****************************************
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_WAKE = 4'b0010,
        ST_CAL  = 4'b0100,
        ST_ACQ  = 4'b1000
    } aocr_state_t;
endpackage : aocr_pkg

// ===== logic/aocr_top.sv
// converter control registers, offset calibration and correction
// assumes an apb master and a front end that hands raw codes by valid/ready
`timescale 1ns/100ps
module aocr_top (
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        smp_valid,
    input  wire logic [15:0] smp_code,
    output logic             smp_ready,
    output logic             fe_power,
    output logic             fe_run,
    output logic             fe_cal,
    output logic             fe_dma_en,
    output logic             fe_mic_power,
    output logic      [31:0] fe_adc_configuration,
    output logic      [15:0] full_scale
);
    // ****************************************
    // decode helpers
    // ****************************************
    function automatic logic aocr_mapped(input logic [11:0] a);
        if (a == aocr_pkg::OFF_CTRL || a == aocr_pkg::OFF_ADC_CONFIGURATION) begin
            return 1'b1;
        end else if (a == aocr_pkg::OFF_MSTAT || a == aocr_pkg::OFF_MASK) begin
            return 1'b1;
        end else if (a == aocr_pkg::OFF_RAW || a == aocr_pkg::OFF_RES) begin
            return 1'b1;
        end else if (a == aocr_pkg::OFF_OFFS || a == aocr_pkg::OFF_STAT) begin
            return 1'b1;
        end else if (a == aocr_pkg::OFF_HI || a == aocr_pkg::OFF_LO) begin
            return 1'b1;
        end else begin
            return 1'b0;
        end
    endfunction : aocr_mapped

    function automatic logic [15:0] aocr_fs(input logic [1:0] oversampling_ratio, input logic byp);
        if (oversampling_ratio[1]) begin
            return byp ? aocr_pkg::FS_LO_BYP : aocr_pkg::FS_LO_FILT;
        end else begin
            return byp ? aocr_pkg::FS_HI_BYP : aocr_pkg::FS_HI_FILT;
        end
    endfunction : aocr_fs

    logic [31:0]               ctrl_r, ctrl_nxt, adc_configuration_r, adc_configuration_nxt;
    logic [31:0]               hi_r, hi_nxt, lo_r, lo_nxt;
    logic [31:0]               offs_r, offs_nxt, res_r, res_nxt;
    logic [3:0]                mask_r, mask_nxt;
    logic [31:0]               prdata_r, prdata_nxt;
    logic                      pready_r, pready_nxt, pslverr_r, pslverr_nxt;
    logic [aocr_pkg::NFLAG-1:0] flag_r, flag_nxt, flag_set, flag_clr;
    aocr_pkg::aocr_state_t     st_r, st_nxt;
    logic [6:0]                wcnt_r, wcnt_nxt;
    logic [15:0]               buf_r [2];
    logic [15:0]               buf_nxt [2];
    logic [1:0]                cnt_r, cnt_nxt;
    logic                      rdy_r, rdy_nxt;
    logic                      run_r, cal_r;
    logic [15:0]               fs_r;
    logic                      wr, wr_ctrl, go, abort, srst, busy, drain, pop;
    logic                      byp, cal_on, cal_pop, acq_pop;
    logic [15:0]               ofh, corr;
    logic [31:0]               res_word;

    // ****************************************
    // bus strobes and control decode
    // ****************************************
    assign wr      = psel & penable & pwrite & pready_r;
    assign wr_ctrl = wr && paddr == aocr_pkg::OFF_CTRL;
    assign srst    = wr_ctrl & pwdata[aocr_pkg::CB_SRST];
    assign abort   = srst | (wr_ctrl & pwdata[aocr_pkg::CB_STOP]);
    assign go      = wr_ctrl & pwdata[aocr_pkg::CB_START] & ~ctrl_r[aocr_pkg::CB_MIC] & ~abort;
    assign busy    = st_r != aocr_pkg::ST_IDLE;
    assign drain   = st_r == aocr_pkg::ST_CAL || st_r == aocr_pkg::ST_ACQ;
    assign pop     = drain && cnt_r != 2'd0 && !abort;
    assign cal_pop = pop && st_r == aocr_pkg::ST_CAL;
    assign acq_pop = pop && st_r == aocr_pkg::ST_ACQ;
    assign byp     = adc_configuration_r[aocr_pkg::FB_BYP];
    assign cal_on  = ctrl_r[aocr_pkg::CB_CALIBRATION_ENABLE] & ctrl_r[aocr_pkg::CB_AUTO];

    // offset half, correction and placement of the code
    assign ofh      = byp ? offs_r[15:0] : offs_r[31:16];
    assign corr     = buf_r[0] - ofh;
    assign res_word = byp ? {{16{corr[15]}}, corr} : {corr, 16'h0000};

    // ****************************************
    // sequencer
    // ****************************************
    always_comb begin
        st_nxt   = st_r;
        wcnt_nxt = wcnt_r;
        case (st_r)
            aocr_pkg::ST_IDLE: begin
                if (go) begin
                    st_nxt   = aocr_pkg::ST_WAKE;
                    wcnt_nxt = 7'(aocr_pkg::WAKE_CYC - 1);
                end
            end
            aocr_pkg::ST_WAKE: begin
                if (wcnt_r == 7'h00) begin
                    st_nxt = cal_on ? aocr_pkg::ST_CAL : aocr_pkg::ST_ACQ;
                end else begin
                    wcnt_nxt = wcnt_r - 7'h01;
                end
            end
            aocr_pkg::ST_CAL: begin
                if (cal_pop) begin
                    st_nxt = aocr_pkg::ST_ACQ;
                end
            end
            aocr_pkg::ST_ACQ: begin
                if (acq_pop && !adc_configuration_r[aocr_pkg::FB_CONTINUOUS_SELECT]) begin
                    st_nxt = aocr_pkg::ST_IDLE;
                end
            end
            default: begin
                st_nxt = aocr_pkg::ST_IDLE;
            end
        endcase
        if (abort) begin
            st_nxt = aocr_pkg::ST_IDLE;
        end
    end

    // ****************************************
    // two-entry sample buffer
    // ****************************************
    always_comb begin
        buf_nxt[0] = buf_r[0];
        buf_nxt[1] = buf_r[1];
        cnt_nxt    = cnt_r;
        if (pop) begin
            buf_nxt[0] = buf_r[1];
            cnt_nxt    = cnt_r - 2'd1;
        end
        if (smp_valid && rdy_r) begin
            buf_nxt[cnt_nxt[0]] = smp_code;
            cnt_nxt             = cnt_nxt + 2'd1;
        end
        if (go || abort) begin
            cnt_nxt = 2'd0;
        end
        rdy_nxt = cnt_nxt != 2'd2;
    end

    // ****************************************
    // register file next values
    // ****************************************
    always_comb begin
        ctrl_nxt = ctrl_r;
        adc_configuration_nxt = adc_configuration_r;
        hi_nxt   = hi_r;
        lo_nxt   = lo_r;
        offs_nxt = offs_r;
        res_nxt  = res_r;
        mask_nxt = mask_r;
        if (wr_ctrl) begin
            ctrl_nxt = (ctrl_r & ~aocr_pkg::CTRL_WMASK) | (pwdata & aocr_pkg::CTRL_WMASK);
            ctrl_nxt[aocr_pkg::CB_CALIBRATION_ENABLE] = ctrl_r[aocr_pkg::CB_CALIBRATION_ENABLE] |
                                           pwdata[aocr_pkg::CB_CALIBRATION_ENABLE];
            if (pwdata[aocr_pkg::CB_CALDS]) begin
                ctrl_nxt[aocr_pkg::CB_CALIBRATION_ENABLE] = 1'b0;
            end
            if (pwdata[aocr_pkg::CB_STOP]) begin
                ctrl_nxt[aocr_pkg::CB_START] = 1'b0;
                ctrl_nxt[aocr_pkg::CB_ON]    = 1'b0;
                ctrl_nxt[aocr_pkg::CB_DMA]   = 1'b0;
                ctrl_nxt[aocr_pkg::CB_MIC]   = 1'b0;
            end
        end
        if (wr && paddr == aocr_pkg::OFF_ADC_CONFIGURATION && !busy) begin
            adc_configuration_nxt = pwdata & aocr_pkg::ADC_CONFIGURATION_WMASK;
        end
        if (wr && paddr == aocr_pkg::OFF_HI) begin
            hi_nxt = pwdata;
        end
        if (wr && paddr == aocr_pkg::OFF_LO) begin
            lo_nxt = pwdata;
        end
        if (wr && paddr == aocr_pkg::OFF_MASK) begin
            mask_nxt = pwdata[3:0];
        end
        if (wr && paddr == aocr_pkg::OFF_OFFS) begin
            offs_nxt = pwdata;
        end
        // calibration capture wins over a software write
        if (cal_pop) begin
            if (byp) begin
                offs_nxt[15:0] = buf_r[0];
            end else begin
                offs_nxt[31:16] = buf_r[0];
            end
        end
        if (acq_pop) begin
            res_nxt = res_word;
            if (!adc_configuration_r[aocr_pkg::FB_CONTINUOUS_SELECT]) begin
                ctrl_nxt[aocr_pkg::CB_START] = 1'b0;
            end
        end
        if (srst) begin
            ctrl_nxt = aocr_pkg::CTRL_RST;
            adc_configuration_nxt = aocr_pkg::ADC_CONFIGURATION_RST;
            res_nxt  = 32'h00000000;
            hi_nxt   = aocr_pkg::HI_RST;
        end
    end

    // ****************************************
    // event flags, set wins over clear
    // ****************************************
    always_comb begin
        flag_set = '0;
        flag_set[aocr_pkg::FL_EOC] = acq_pop;
        flag_set[aocr_pkg::FL_CAL] = cal_pop;
        flag_set[aocr_pkg::FL_WIN] = acq_pop & ctrl_r[aocr_pkg::CB_WCMP] &
                                     ($signed(res_word) >= $signed(lo_r)) &
                                     ($signed(res_word) <= $signed(hi_r));
        flag_clr = '0;
        if (wr && paddr == aocr_pkg::OFF_STAT) begin
            flag_clr = pwdata[aocr_pkg::NFLAG:1];
        end
    end

    generate
        for (genvar i = 0; i < aocr_pkg::NFLAG; i++) begin : g_flag
            assign flag_nxt[i] = flag_set[i] | (flag_r[i] & ~flag_clr[i]);
        end
    endgenerate

    // ****************************************
    // apb read path, one setup and one access cycle
    // ****************************************
    always_comb begin
        prdata_nxt  = 32'h00000000;
        pready_nxt  = psel & ~penable;
        pslverr_nxt = psel & ~penable & ~aocr_mapped(paddr);
        if (psel && !penable) begin
            if (paddr == aocr_pkg::OFF_CTRL) begin
                prdata_nxt = ctrl_r;
            end else if (paddr == aocr_pkg::OFF_ADC_CONFIGURATION) begin
                prdata_nxt = adc_configuration_r;
            end else if (paddr == aocr_pkg::OFF_MSTAT) begin
                prdata_nxt = {29'h0, flag_r & ~mask_r[2:0]};
            end else if (paddr == aocr_pkg::OFF_MASK) begin
                prdata_nxt = {28'h0, mask_r};
            end else if (paddr == aocr_pkg::OFF_RAW) begin
                prdata_nxt = {29'h0, flag_r};
            end else if (paddr == aocr_pkg::OFF_RES) begin
                prdata_nxt = res_r;
            end else if (paddr == aocr_pkg::OFF_OFFS) begin
                prdata_nxt = offs_r;
            end else if (paddr == aocr_pkg::OFF_STAT) begin
                prdata_nxt = {28'h0, flag_r, busy};
            end else if (paddr == aocr_pkg::OFF_HI) begin
                prdata_nxt = hi_r;
            end else if (paddr == aocr_pkg::OFF_LO) begin
                prdata_nxt = lo_r;
            end
        end
    end

    // ****************************************
    // state registers
    // ****************************************
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ctrl_r    <= aocr_pkg::CTRL_RST;
            adc_configuration_r    <= aocr_pkg::ADC_CONFIGURATION_RST;
            hi_r      <= aocr_pkg::HI_RST;
            lo_r      <= 32'h00000000;
            offs_r    <= 32'h00000000;
            res_r     <= 32'h00000000;
            mask_r    <= aocr_pkg::MASK_RST;
            flag_r    <= '0;
            st_r      <= aocr_pkg::ST_IDLE;
            wcnt_r    <= 7'h00;
            buf_r[0]  <= 16'h0000;
            buf_r[1]  <= 16'h0000;
            cnt_r     <= 2'd0;
            rdy_r     <= 1'b0;
            prdata_r  <= 32'h00000000;
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            run_r     <= 1'b0;
            cal_r     <= 1'b0;
            fs_r      <= aocr_pkg::FS_HI_FILT;
        end else begin
            ctrl_r    <= ctrl_nxt;
            adc_configuration_r    <= adc_configuration_nxt;
            hi_r      <= hi_nxt;
            lo_r      <= lo_nxt;
            offs_r    <= offs_nxt;
            res_r     <= res_nxt;
            mask_r    <= mask_nxt;
            flag_r    <= flag_nxt;
            st_r      <= st_nxt;
            wcnt_r    <= wcnt_nxt;
            buf_r[0]  <= buf_nxt[0];
            buf_r[1]  <= buf_nxt[1];
            cnt_r     <= cnt_nxt;
            rdy_r     <= rdy_nxt;
            prdata_r  <= prdata_nxt;
            pready_r  <= pready_nxt;
            pslverr_r <= pslverr_nxt;
            run_r     <= st_nxt != aocr_pkg::ST_IDLE;
            cal_r     <= st_nxt == aocr_pkg::ST_CAL;
            fs_r      <= aocr_fs(adc_configuration_nxt[aocr_pkg::FB_OSR +: 2], adc_configuration_nxt[aocr_pkg::FB_BYP]);
        end
    end

    // outputs straight from flops
    assign prdata       = prdata_r;
    assign pready       = pready_r;
    assign pslverr      = pslverr_r;
    assign smp_ready    = rdy_r;
    assign fe_power     = ctrl_r[aocr_pkg::CB_ON];
    assign fe_run       = run_r;
    assign fe_cal       = cal_r;
    assign fe_dma_en    = ctrl_r[aocr_pkg::CB_DMA];
    assign fe_mic_power = ctrl_r[aocr_pkg::CB_MIC];
    assign fe_adc_configuration      = adc_configuration_r;
    assign full_scale   = fs_r;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    sequence s_go;
        go ##1 (st_r == aocr_pkg::ST_WAKE);
    endsequence
    sequence s_wake;
        (st_r == aocr_pkg::ST_WAKE & ~abort)[*8];
    endsequence

    // a stop may cut the wake phase at any time, so only an unbroken wake is followed
    AST_START: assert property (s_go ##1 s_wake |=> fe_run && st_r == aocr_pkg::ST_WAKE)
        else $error("no wake after start");
    AST_CALCAP: assert property (cal_pop & ~byp & ~abort |=>
        offs_r[31:16] == $past(buf_r[0]) && flag_r[aocr_pkg::FL_CAL])
        else $error("offset not captured");
    AST_SUB: assert property (acq_pop & ~byp & ~srst |=>
        res_r[31:16] == $past(buf_r[0]) - $past(offs_r[31:16]) &&
        res_r[15:0] == 16'h0000 && flag_r[aocr_pkg::FL_EOC])
        else $error("bad corrected result");
    AST_LOWER: assert property (acq_pop & byp & ~srst |=>
        res_r[15:0] == $past(buf_r[0]) - $past(offs_r[15:0]) &&
        res_r[31:16] == {16{res_r[15]}})
        else $error("bad bypass result");
    AST_FS: assert property (adc_configuration_r[aocr_pkg::FB_OSR+1] & ~byp & $stable(adc_configuration_r) |->
        full_scale == aocr_pkg::FS_LO_FILT) else $error("bad full scale");
    AST_CALIBRATION_ENABLE: assert property (wr_ctrl & ctrl_r[aocr_pkg::CB_CALIBRATION_ENABLE] &
        ~pwdata[aocr_pkg::CB_CALDS] & ~srst |=> ctrl_r[aocr_pkg::CB_CALIBRATION_ENABLE])
        else $error("calibration enable dropped");
    AST_CALDS: assert property (wr_ctrl & pwdata[aocr_pkg::CB_CALDS] |=>
        !ctrl_r[aocr_pkg::CB_CALIBRATION_ENABLE] && !ctrl_r[aocr_pkg::CB_CALDS])
        else $error("calibration disable failed");
    AST_SRST: assert property (srst |=> adc_configuration_r == aocr_pkg::ADC_CONFIGURATION_RST &&
        hi_r == aocr_pkg::HI_RST && res_r == 32'h0 && ctrl_r == 32'h0)
        else $error("soft reset incomplete");
    AST_STOP: assert property (wr_ctrl & pwdata[aocr_pkg::CB_STOP] |=>
        !fe_power && !fe_mic_power && !fe_dma_en && !busy ##1 !fe_run)
        else $error("stop incomplete");
    AST_LOCK: assert property (busy & ~srst |=> $stable(adc_configuration_r))
        else $error("config changed while busy");
    AST_SINGLE: assert property (acq_pop & ~adc_configuration_r[aocr_pkg::FB_CONTINUOUS_SELECT] |=>
        !busy && !ctrl_r[aocr_pkg::CB_START]) else $error("single did not stop");
    AST_MASK: assert property (psel & ~penable && paddr == aocr_pkg::OFF_MSTAT |=>
        prdata[2:0] == ($past(flag_r) & ~$past(mask_r[2:0])))
        else $error("masked status wrong");
endmodule : aocr_top

// ===== sim/aocr_fe_model.sv
// front end model: hands raw codes to the block over valid/ready
// assumes ref_clk from the bench and a registered smp_ready from the block
`timescale 1ns/100ps
module aocr_fe_model (
    input  wire logic        ref_clk,
    input  wire logic        smp_ready,
    output logic             smp_valid,
    output logic      [15:0] smp_code
);
    logic lost; // set when an offer was never taken
    // idle: no offer, code starts at A5A5, later the inverse of the last word
    initial begin
        smp_valid = 1'b0;
        smp_code  = 16'hA5A5;
        lost      = 1'b0;
    end
    // offer one code, hold it until taken, bounded wait
    task automatic send(input logic [15:0] code);
        int i;
        @(negedge ref_clk);
        smp_valid = 1'b1;
        smp_code  = code;
        i = 0;
        do begin
            @(posedge ref_clk);
            i++;
        end while (smp_ready !== 1'b1 && i < 500);
        if (smp_ready !== 1'b1) lost = 1'b1;
        @(negedge ref_clk);
        smp_valid = 1'b0;
        smp_code  = ~code; // released bus no longer shows the word
    endtask : send
endmodule : aocr_fe_model

// ===== sim/test_adc_offset_and_control_regs.sv
// bench for the converter control register block
// assumes aocr_top with apb registers and the front end model beside it
`timescale 1ns/100ps
module test_adc_offset_and_control_regs;
    logic ref_clk, rst_n, psel, penable, pwrite, pready, pslverr, last_err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic smp_valid, smp_ready, fe_power, fe_run, fe_cal, fe_dma_en, fe_mic_power;
    logic [15:0] smp_code, full_scale;
    logic [31:0] fe_adc_configuration;
    int fail_count, n_tests;
    // ****************************************
    // tables
    // ****************************************
    logic [11:0] rs_a [11] = '{12'h000, 12'h004, 12'h008, 12'h00C, 12'h010, 12'h014,
                               12'h018, 12'h020, 12'h024, 12'h028, 12'h01C};
    logic [31:0] rs_e [11] = '{32'h0, 32'h0000000C, 32'h0, 32'h0000000F, 32'h0, 32'h0,
                               32'h0, 32'h0, 32'h0FFFFFFF, 32'h0, 32'h0};
    logic [31:0] fs_c [4] = '{32'h000000CC, 32'h0004000C, 32'h000400CC, 32'h0000000C};
    logic [15:0] fs_e [4] = '{16'h4144, 16'h9503, 16'h8000, 16'h4BFA};
    aocr_top dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .smp_valid(smp_valid), .smp_code(smp_code),
        .smp_ready(smp_ready), .fe_power(fe_power), .fe_run(fe_run), .fe_cal(fe_cal),
        .fe_dma_en(fe_dma_en), .fe_mic_power(fe_mic_power), .fe_adc_configuration(fe_adc_configuration),
        .full_scale(full_scale));
    aocr_fe_model fe_u (.ref_clk(ref_clk), .smp_ready(smp_ready), .smp_valid(smp_valid),
        .smp_code(smp_code));
    // clock, 100 ns period
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : final_report
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    // one apb transfer, setup then access, bounded wait on pready
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(negedge ref_clk);
        psel = 1'b1;
        penable = 1'b0;
        pwrite = w;
        paddr = a;
        pwdata = d;
        @(negedge ref_clk);
        penable = 1'b1;
        i = 0;
        do begin
            @(posedge ref_clk);
            i++;
        end while (pready !== 1'b1 && i < 4);
        if (i >= 4) begin
            fail_count++;
            final_report();
        end
        q = prdata;
        last_err = pslverr;
        @(negedge ref_clk);
        psel = 1'b0;
        penable = 1'b0;
    endtask : apb
    // poll raw flags until the wanted ones are set
    task automatic wait_raw(input logic [31:0] m);
        int i;
        i = 0;
        do begin
            apb(1'b0, 12'h010, 32'h0);
            i++;
        end while ((q & m) !== m && i < 200);
        if (i >= 200) begin
            fail_count++;
            final_report();
        end
    endtask : wait_raw
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        {rst_n, psel, penable, pwrite, paddr, pwdata, last_err} = '0;
        fail_count = 0;
        n_tests = 0;
        repeat (5) @(negedge ref_clk);
        rst_n = 1'b1;
        // reset values, unmapped place answers with an error
        for (int k = 0; k < 11; k++) begin
            apb(1'b0, rs_a[k], 32'h0);
            check("reset read", q, rs_e[k]);
            check("slave error", {31'h0, last_err}, {31'h0, k == 10});
        end
        // full-scale factor per ratio and bypass
        for (int k = 0; k < 4; k++) begin
            apb(1'b1, 12'h004, fs_c[k]);
            repeat (2) @(negedge ref_clk);
            check("full scale", {16'h0, full_scale}, {16'h0, fs_e[k]});
        end
        // auto calibration with power on, config write refused while busy
        apb(1'b1, 12'h000, 32'h00000087);
        apb(1'b1, 12'h004, 32'h000000CC);
        apb(1'b0, 12'h020, 32'h0);
        check("busy", q & 32'h1, 32'h1);
        repeat (70) @(negedge ref_clk);
        check("cal phase", {31'h0, fe_cal}, 32'h1);
        fe_u.send(16'h0010);
        fe_u.send(16'h0110);
        wait_raw(32'h3);
        check("raw flags", q, 32'h3);
        apb(1'b0, 12'h004, 32'h0);
        check("config", q, 32'h0000000C);
        check("adc_configuration port", fe_adc_configuration, 32'h0000000C);
        apb(1'b0, 12'h018, 32'h0);
        check("offset", q, 32'h00100000);
        apb(1'b0, 12'h014, 32'h0);
        check("result", q, 32'h01000000);
        apb(1'b0, 12'h008, 32'h0);
        check("masked", q, 32'h0);
        apb(1'b0, 12'h000, 32'h0);
        check("control", q, 32'h00000087 & 32'hFFFFFFFB);
        apb(1'b1, 12'h000, 32'h0);
        apb(1'b0, 12'h000, 32'h0);
        check("cal enable kept", q, 32'h00000002);
        apb(1'b1, 12'h000, 32'h00000040);
        apb(1'b0, 12'h000, 32'h0);
        check("cal disabled", q, 32'h0);
        // stored offset reused, inclusive upper window bound, unmasked flags
        apb(1'b1, 12'h020, 32'h0000000E);
        apb(1'b1, 12'h00C, 32'h0);
        apb(1'b1, 12'h024, 32'h01100000);
        apb(1'b1, 12'h000, 32'h00000025);
        fe_u.send(16'h0120);
        wait_raw(32'h1);
        apb(1'b0, 12'h008, 32'h0);
        check("masked flags", q, 32'h5);
        apb(1'b0, 12'h014, 32'h0);
        check("manual result", q, 32'h01100000);
        // bypassed path, negative result outside the window
        apb(1'b1, 12'h020, 32'h0000000E);
        apb(1'b1, 12'h004, 32'h0004000C);
        apb(1'b1, 12'h018, 32'h00000005);
        apb(1'b1, 12'h000, 32'h00000025);
        fe_u.send(16'hFFF0);
        wait_raw(32'h1);
        check("bypass flags", q, 32'h1);
        apb(1'b0, 12'h014, 32'h0);
        check("bypass result", q, 32'hFFFFFFEB);
        // continuous run, then stop clears start, power, dma, microphone
        apb(1'b1, 12'h004, 32'h0000080C);
        apb(1'b1, 12'h020, 32'h0000000E);
        apb(1'b1, 12'h000, 32'h00000305);
        check("running", {31'h0, fe_run}, 32'h1);
        fe_u.send(16'h0200);
        fe_u.send(16'h0300);
        wait_raw(32'h1);
        apb(1'b0, 12'h014, 32'h0);
        check("continuous result", q, 32'h03000000);
        apb(1'b0, 12'h020, 32'h0);
        check("still busy", q & 32'h1, 32'h1);
        apb(1'b1, 12'h000, 32'h00000010);
        apb(1'b0, 12'h000, 32'h0);
        check("stopped", q, 32'h0);
        check("front end", {28'h0, fe_run, fe_power, fe_dma_en, fe_mic_power}, 32'h0);
        // start ignored while microphone power is on
        apb(1'b1, 12'h000, 32'h00000100);
        apb(1'b1, 12'h000, 32'h00000104);
        check("mic start", {30'h0, fe_run, fe_mic_power}, 32'h1);
        // soft reset restores chosen registers only
        apb(1'b1, 12'h024, 32'h00000123);
        apb(1'b1, 12'h028, 32'h00000077);
        apb(1'b1, 12'h000, 32'h00000008);
        for (int k = 0; k < 4; k++) begin
            apb(1'b0, k == 3 ? 12'h000 : k == 2 ? 12'h028 : 12'h014 + 12'h010 * k[11:0], 32'h0);
            check("soft reset", q, k == 1 ? 32'h0FFFFFFF : k == 2 ? 32'h77 : 32'h0);
        end
        apb(1'b0, 12'h004, 32'h0);
        check("soft reset adc_configuration", q, 32'h0000000C);
        check("samples taken", {31'h0, fe_u.lost}, 32'h0);
        final_report();
    end
endmodule : test_adc_offset_and_control_regs
